// ==== rtl/mem_width_pack.sv ====
// memory width adapter: splits internal accesses into external beats
// assumes one command per beat, read data returned with ext_rdata_valid
`default_nettype none
`include "mem_pack_map.svh"

module mem_width_pack #(
    parameter int GENERATION  = 3,
    parameter bit NARROW_PORT = 1'b0
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    srst,
    // configuration
    input  wire logic                    little_endian_select,
    input  wire mem_pack_pkg::mem_kind_e mem_kind,
    input  wire logic [1:0]              mem_wlog,
    input  wire logic                    chip_enable_space_one,
    // internal request
    input  wire logic                    req_valid,
    input  wire logic                    req_write,
    input  wire logic [1:0]              req_size,
    input  wire logic [31:0]             req_addr,
    input  wire logic [`DATA_W-1:0]      req_wdata,
    output logic                         req_ready,
    // internal answer
    output logic                         rsp_valid,
    output logic                         rsp_error,
    output logic [`DATA_W-1:0]           rsp_rdata,
    // external memory side
    output logic [`ADDR_BUS_W-1:0]       external_address_bus,
    output logic                         ext_cmd,
    output logic                         ext_write,
    output logic [`DATA_LANES-1:0]       ext_byte_en,
    output logic [`DATA_W-1:0]           ext_data_out,
    output logic                         ext_data_oe,
    input  wire logic [`DATA_W-1:0]      ext_data_in,
    input  wire logic                    ext_rdata_valid
);

    localparam int PIN_BASE = (GENERATION < 3) ? `PIN_BASE_EARLY :
                              (NARROW_PORT ? `PIN_BASE_NARROW : `PIN_BASE_WIDE);
    localparam bit FIRST_GEN = (GENERATION == 1);

    // captured request
    mem_pack_pkg::state_e    state_r;
    mem_pack_pkg::state_e    state_nxt;
    logic                    wr_r;
    logic                    wr_nxt;
    logic [1:0]              size_r;
    logic [1:0]              size_nxt;
    logic [31:0]             addr_r;
    logic [31:0]             addr_nxt;
    logic [`DATA_W-1:0]      wdata_r;
    logic [`DATA_W-1:0]      wdata_nxt;
    mem_pack_pkg::mem_kind_e kind_r;
    mem_pack_pkg::mem_kind_e kind_nxt;
    logic [1:0]              wlog_r;
    logic [1:0]              wlog_nxt;
    logic                    le_r;
    logic                    le_nxt;
    logic                    one_r;
    logic                    one_nxt;
    logic [2:0]              beat_r;
    logic [2:0]              beat_nxt;
    logic [`DATA_W-1:0]      asm_r;
    logic [`DATA_W-1:0]      asm_nxt;

    // output next values
    logic                    req_ready_nxt;
    logic                    rsp_valid_nxt;
    logic                    rsp_error_nxt;
    logic [`DATA_W-1:0]      rsp_rdata_nxt;
    logic [`ADDR_BUS_W-1:0]  ext_addr_nxt;
    logic                    ext_cmd_nxt;
    logic                    ext_write_nxt;
    logic [`DATA_LANES-1:0]  ext_byte_en_nxt;
    logic [`DATA_W-1:0]      ext_data_out_nxt;
    logic                    ext_data_oe_nxt;

    // steering
    logic                    le_eff;
    logic [2:0]              steer_beat;
    logic [2:0]              a0;
    logic [1:0]              beats_log;
    logic [2:0]              last_beat;
    logic [7:0]              lane_en;
    logic [23:0]             lane_src;
    logic [`ADDR_BUS_W-1:0]  shift_pins;
    logic                    in_range;
    logic [`DATA_W-1:0]      steer_data;
    logic                    width_ok;
    logic                    size_ok;
    logic                    aligned;
    logic                    legal;
    logic                    issue;

    assign le_eff = (FIRST_GEN && wlog_r != `WLOG_X32) ? 1'b1 : le_r;

    // next beat is steered while the gap cycle runs
    assign steer_beat = (state_r == mem_pack_pkg::ST_GAP) ? beat_r + 3'h1 : beat_r;
    assign a0 = addr_r[2:0] & 3'((4'h1 << wlog_r) - 4'h1);

    assign beats_log = (size_r > wlog_r) ? size_r - wlog_r : 2'h0;
    assign last_beat = 3'((4'h1 << beats_log) - 4'h1);

    always_comb begin
        unique case (GENERATION)
            1: width_ok = (wlog_r == `WLOG_X32)
                          || (one_r && !wr_r && kind_r == mem_pack_pkg::KIND_ASYNC
                              && wlog_r != `WLOG_X64);
            2: width_ok = (wlog_r != `WLOG_X64);
            default: width_ok = NARROW_PORT ? (wlog_r <= `WLOG_X16) : 1'b1;
        endcase
    end

    // 64-bit internal accesses exist only on the third generation
    assign size_ok = (GENERATION == 3) || (size_r != 2'h3);
    assign aligned = (addr_r[2:0] & 3'((4'h1 << size_r) - 4'h1)) == 3'h0;
    assign legal   = width_ok && size_ok && aligned && in_range;

    lane_steer u_lane_steer (
        .wlog     (wlog_r),
        .size     (size_r),
        .le       (le_eff),
        .beat     (steer_beat),
        .a0       (a0),
        .lane_en  (lane_en),
        .lane_src (lane_src)
    );

    addr_shift #(
        .PIN_BASE  (PIN_BASE),
        .FIRST_GEN (FIRST_GEN)
    ) u_addr_shift (
        .byte_addr (addr_r),
        .wlog      (wlog_r),
        .beat      (steer_beat),
        .kind      (kind_r),
        .pins      (shift_pins),
        .in_range  (in_range)
    );

    genvar j;
    generate
        for (j = 0; j < `DATA_LANES; j++) begin : g_wlane
            assign steer_data[8*j +: 8] = lane_en[j] ? wdata_r[8*lane_src[3*j +: 3] +: 8]
                                                     : 8'h00;
        end
    endgenerate

    always_comb begin
        state_nxt        = state_r;
        wr_nxt           = wr_r;
        size_nxt         = size_r;
        addr_nxt         = addr_r;
        wdata_nxt        = wdata_r;
        kind_nxt         = kind_r;
        wlog_nxt         = wlog_r;
        le_nxt           = le_r;
        one_nxt          = one_r;
        beat_nxt         = beat_r;
        asm_nxt          = asm_r;
        req_ready_nxt    = req_ready;
        rsp_valid_nxt    = 1'b0;
        rsp_error_nxt    = 1'b0;
        rsp_rdata_nxt    = rsp_rdata;
        ext_addr_nxt     = external_address_bus;
        ext_cmd_nxt      = 1'b0;
        ext_write_nxt    = ext_write;
        ext_byte_en_nxt  = ext_byte_en;
        ext_data_out_nxt = ext_data_out;
        ext_data_oe_nxt  = 1'b0;
        issue            = 1'b0;
        unique case (state_r)
            mem_pack_pkg::ST_IDLE: begin
                if (req_valid && req_ready) begin
                    wr_nxt        = req_write;
                    size_nxt      = req_size;
                    addr_nxt      = req_addr;
                    wdata_nxt     = req_wdata;
                    kind_nxt      = mem_kind;
                    wlog_nxt      = mem_wlog;
                    le_nxt        = little_endian_select;
                    one_nxt       = chip_enable_space_one;
                    beat_nxt      = 3'h0;
                    asm_nxt       = '0;
                    req_ready_nxt = 1'b0;
                    state_nxt     = mem_pack_pkg::ST_CHECK;
                end
            end
            mem_pack_pkg::ST_CHECK: begin
                if (legal) begin
                    issue = 1'b1;
                end else begin
                    rsp_valid_nxt = 1'b1;
                    rsp_error_nxt = 1'b1;
                    rsp_rdata_nxt = '0;
                    req_ready_nxt = 1'b1;
                    state_nxt     = mem_pack_pkg::ST_IDLE;
                end
            end
            mem_pack_pkg::ST_CMD: begin
                state_nxt = wr_r ? mem_pack_pkg::ST_GAP : mem_pack_pkg::ST_WAIT;
            end
            mem_pack_pkg::ST_WAIT: begin
                if (ext_rdata_valid) begin
                    for (int k = 0; k < `DATA_LANES; k++) begin
                        if (lane_en[k])
                            asm_nxt[8*lane_src[3*k +: 3] +: 8] = ext_data_in[8*k +: 8];
                    end
                    state_nxt = mem_pack_pkg::ST_GAP;
                end
            end
            mem_pack_pkg::ST_GAP: begin
                if (beat_r == last_beat) begin
                    rsp_valid_nxt = 1'b1;
                    rsp_rdata_nxt = wr_r ? '0 : asm_r;
                    req_ready_nxt = 1'b1;
                    state_nxt     = mem_pack_pkg::ST_IDLE;
                end else begin
                    beat_nxt = beat_r + 3'h1;
                    issue    = 1'b1;
                end
            end
            default: begin
                req_ready_nxt = 1'b1;
                state_nxt     = mem_pack_pkg::ST_IDLE;
            end
        endcase
        if (issue) begin
            ext_cmd_nxt      = 1'b1;
            ext_write_nxt    = wr_r;
            ext_addr_nxt     = shift_pins;
            ext_byte_en_nxt  = lane_en;
            ext_data_out_nxt = wr_r ? steer_data : '0;
            ext_data_oe_nxt  = wr_r;
            state_nxt        = mem_pack_pkg::ST_CMD;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_r              <= mem_pack_pkg::ST_IDLE;
            wr_r                 <= 1'b0;
            size_r               <= 2'h0;
            addr_r               <= 32'h0;
            wdata_r              <= '0;
            kind_r               <= mem_pack_pkg::KIND_ASYNC;
            wlog_r               <= `WLOG_X32;
            le_r                 <= 1'b1;
            one_r                <= 1'b0;
            beat_r               <= 3'h0;
            asm_r                <= '0;
            req_ready            <= 1'b1;
            rsp_valid            <= 1'b0;
            rsp_error            <= 1'b0;
            rsp_rdata            <= '0;
            external_address_bus <= '0;
            ext_cmd              <= 1'b0;
            ext_write            <= 1'b0;
            ext_byte_en          <= '0;
            ext_data_out         <= '0;
            ext_data_oe          <= 1'b0;
        end else begin
            state_r              <= state_nxt;
            wr_r                 <= wr_nxt;
            size_r               <= size_nxt;
            addr_r               <= addr_nxt;
            wdata_r              <= wdata_nxt;
            kind_r               <= kind_nxt;
            wlog_r               <= wlog_nxt;
            le_r                 <= le_nxt;
            one_r                <= one_nxt;
            beat_r               <= beat_nxt;
            asm_r                <= asm_nxt;
            req_ready            <= req_ready_nxt;
            rsp_valid            <= rsp_valid_nxt;
            rsp_error            <= rsp_error_nxt;
            rsp_rdata            <= rsp_rdata_nxt;
            external_address_bus <= ext_addr_nxt;
            ext_cmd              <= ext_cmd_nxt;
            ext_write            <= ext_write_nxt;
            ext_byte_en          <= ext_byte_en_nxt;
            ext_data_out         <= ext_data_out_nxt;
            ext_data_oe          <= ext_data_oe_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_byte_beat;
        ext_cmd && ext_write && wlog_r == `WLOG_X8 && beat_r != last_beat;
    endsequence

    sequence s_next_byte;
        ##2 ext_cmd && external_address_bus
            == $past(external_address_bus, 2) + (`ADDR_BUS_W'(1) << PIN_BASE);
    endsequence

    a_cmd_spacing: assert property (ext_cmd |=> !ext_cmd)
        else $error("two external commands back to back");

    a_bus_quiet: assert property (state_r == mem_pack_pkg::ST_WAIT |-> !ext_data_oe)
        else $error("write data driven while read data expected");

    a_byte_order: assert property (s_byte_beat |-> s_next_byte)
        else $error("byte beats not at consecutive addresses");

    a_lane_zero: assert property (ext_cmd |-> (ext_byte_en >> (4'h1 << wlog_r)) == 8'h00)
        else $error("byte enable above memory width");

    a_first_width: assert property (FIRST_GEN && ext_cmd && wlog_r != `WLOG_X32
                                    |-> one_r && !ext_write)
        else $error("narrow access outside read-only space one");

    a_rom_little: assert property (FIRST_GEN && ext_cmd && wlog_r != `WLOG_X32 |-> le_eff)
        else $error("narrow read-only memory not packed little-endian");

    a_narrow_width: assert property (ext_cmd && NARROW_PORT |-> wlog_r <= `WLOG_X16)
        else $error("narrow port driven with wide memory");

    a_addr_first: assert property (ext_cmd && beat_r == 3'h0 |-> external_address_bus
        == `ADDR_BUS_W'(((addr_r >> wlog_r) & 32'hFFFFF) << PIN_BASE))
        else $error("first beat address not shifted by width");

    a_error_quiet: assert property (state_r == mem_pack_pkg::ST_CHECK && !legal
                                    |=> rsp_error && !ext_cmd)
        else $error("illegal access not refused");

endmodule : mem_width_pack

`default_nettype wire

// ==== shared/mem_pack_map.svh ====
// constants of the memory width adapter: pin placement, spans, encodings
// assumes inclusion by bare name from design and bench files
`ifndef MEM_PACK_MAP_SVH
`define MEM_PACK_MAP_SVH

// external address pins carry a 20-bit unit address
`define ADDR_PINS           20
`define ADDR_BUS_W          23
`define PIN_BASE_EARLY      2
`define PIN_BASE_WIDE       3
`define PIN_BASE_NARROW     1

// data path: eight byte lanes, lane 0 on the low data bits
`define DATA_LANES          8
`define DATA_W              64

// memory width as log2 of bytes
`define WLOG_X8             2'h0
`define WLOG_X16            2'h1
`define WLOG_X32            2'h2
`define WLOG_X64            2'h3

// per-space spans as log2 of memory-width units; the old sdram span is log2 of bytes
`define STATIC_SPAN_LOG     20
`define SDRAM_SPAN_LOG_OLD  24
`define SDRAM_SPAN_LOG_NEW  25

`endif

// ==== shared/mem_pack_pkg.sv ====
// types shared by the memory width adapter
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package mem_pack_pkg;

    typedef enum logic [1:0] {
        KIND_ASYNC = 2'b00,
        KIND_SYNC  = 2'b01,
        KIND_SDRAM = 2'b10
    } mem_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_CMD   = 3'b010,
        ST_WAIT  = 3'b011,
        ST_GAP   = 3'b100
    } state_e;

    typedef logic [1:0] wlog_t;

endpackage : mem_pack_pkg

`default_nettype wire

// ==== rtl/lane_steer.sv ====
// byte lane steering for one external beat
// assumes accesses aligned to their size; pure combinational
`default_nettype none
`include "mem_pack_map.svh"

module lane_steer (
    // beat description
    input  wire logic [1:0]  wlog,
    input  wire logic [1:0]  size,
    input  wire logic        le,
    input  wire logic [2:0]  beat,
    input  wire logic [2:0]  a0,
    // per-lane result
    output logic [7:0]       lane_en,
    output logic [23:0]      lane_src
);

    genvar j;
    generate
        for (j = 0; j < `DATA_LANES; j++) begin : g_lane
            logic       en_l;
            logic [2:0] src_l;
            always_comb begin
                int w;
                int a;
                int m;
                int o;
                w = 1 << wlog;
                a = 1 << size;
                m = le ? j : w - 1 - j;
                o = int'(beat) * w + m - int'(a0);
                en_l = (j < w) && (o >= 0) && (o < a);
                src_l = le ? 3'(o) : 3'(a - 1 - o);
            end
            assign lane_en[j]         = en_l;
            assign lane_src[3*j +: 3] = src_l;
        end
    endgenerate

endmodule : lane_steer

`default_nettype wire

// ==== rtl/addr_shift.sv ====
// external unit address and span check for one beat
// assumes byte address aligned to the access size
`default_nettype none
`include "mem_pack_map.svh"

module addr_shift #(
    parameter int PIN_BASE  = `PIN_BASE_WIDE,
    parameter bit FIRST_GEN = 1'b0
) (
    // beat description
    input  wire logic [31:0]            byte_addr,
    input  wire logic [1:0]             wlog,
    input  wire logic [2:0]             beat,
    input  wire mem_pack_pkg::mem_kind_e kind,
    // result
    output logic [`ADDR_BUS_W-1:0]      pins,
    output logic                        in_range
);

    logic [31:0] unit;
    int          span_log;

    assign unit = (byte_addr >> wlog) + 32'(beat);
    assign pins = `ADDR_BUS_W'({unit[`ADDR_PINS-1:0]} << PIN_BASE);

    always_comb begin
        if (kind == mem_pack_pkg::KIND_SDRAM)
            span_log = FIRST_GEN ? `SDRAM_SPAN_LOG_OLD : `SDRAM_SPAN_LOG_NEW + int'(wlog);
        else
            span_log = `STATIC_SPAN_LOG + int'(wlog);
    end

    assign in_range = (byte_addr >> span_log) == 32'h0;

endmodule : addr_shift

`default_nettype wire

// ==== dv/mem_partner.sv ====
// external memory model: lane storage, read answer after a chosen lag
// assumes the wide port of the third generation, unit address from pin 3 up
`default_nettype none
`include "mem_pack_map.svh"

module mem_partner (
    // clock and memory shape
    input  wire logic                   clock,
    input  wire logic [1:0]             wlog,
    input  wire logic [1:0]             lag,
    // command side
    input  wire logic                   ext_cmd,
    input  wire logic                   ext_write,
    input  wire logic [`DATA_LANES-1:0] ext_byte_en,
    input  wire logic [`ADDR_BUS_W-1:0] external_address_bus,
    input  wire logic [`DATA_W-1:0]     ext_data_out,
    // read answer
    output logic [`DATA_W-1:0]          ext_data_in,
    output logic                        ext_rdata_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [63:0] store [0:255];
    logic [63:0] held;
    logic [63:0] keep;
    logic [7:0]  unit;
    int          wait_n;

    assign unit = 8'(external_address_bus >> `PIN_BASE_WIDE);
    // lanes above the memory width are not wired, so they carry junk
    assign keep = ~({64{1'b1}} << (8 << wlog));

    initial begin
        foreach (store[i]) store[i] = 64'h0;
        wait_n = -1;
        held = 64'h0;
        ext_data_in = 64'hA5C3_0F96_5A3C_F069;
        ext_rdata_valid = 1'b0;
    end

    always @(posedge clock) begin
        ext_rdata_valid <= 1'b0;
        // released data lines toggle so a stale value never passes
        ext_data_in <= ~ext_data_in;
        if (ext_cmd && ext_write) begin
            for (int j = 0; j < 8; j++) begin
                if (ext_byte_en[j]) store[unit][8*j+:8] <= ext_data_out[8*j+:8];
            end
        end else if (ext_cmd) begin
            held <= store[unit];
            wait_n <= lag;
        end else if (wait_n == 0) begin
            ext_rdata_valid <= 1'b1;
            ext_data_in <= (held & keep) | (~ext_data_in & ~keep);
            wait_n <= -1;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end
    end
endmodule : mem_partner

`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the width adapter, wide port, third generation
// assumes the memory model answers reads and stores writes by lanes
`default_nettype none
`include "mem_pack_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock, srst, little_endian_select, chip_enable_space_one;
    logic req_valid, req_write, req_ready, rsp_valid, rsp_error;
    logic ext_cmd, ext_write, ext_data_oe, ext_rdata_valid, last_cmd;
    logic [1:0] mem_wlog, req_size, lag, rs;
    logic [31:0] req_addr;
    logic [63:0] req_wdata, rsp_rdata, ext_data_out, ext_data_in, w;
    logic [7:0] ext_byte_en;
    logic [`ADDR_BUS_W-1:0] external_address_bus;
    // first-generation copy on the same requests, so its narrow rom paths are reached
    logic g_ready, g_valid, g_error, g_cmd, g_write, g_oe, g_rvalid;
    logic [63:0] g_rdata, g_dout, g_din;
    logic [7:0] g_be;
    logic [`ADDR_BUS_W-1:0] g_addr;
    mem_pack_pkg::mem_kind_e mem_kind;
    logic [19:0] bq_addr[$];
    logic [7:0] bq_be[$], bq_d0[$];
    logic [7:0] ref_mem [0:2047];
    int error_cnt, cmp_count;

    mem_width_pack DUT (.clock(clock), .srst(srst),
        .little_endian_select(little_endian_select), .mem_kind(mem_kind),
        .mem_wlog(mem_wlog), .chip_enable_space_one(chip_enable_space_one),
        .req_valid(req_valid), .req_write(req_write), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
        .external_address_bus(external_address_bus), .ext_cmd(ext_cmd),
        .ext_write(ext_write), .ext_byte_en(ext_byte_en), .ext_data_out(ext_data_out),
        .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
        .ext_rdata_valid(ext_rdata_valid));

    mem_partner memory (.clock(clock), .wlog(mem_wlog), .lag(lag), .ext_cmd(ext_cmd),
        .ext_write(ext_write), .ext_byte_en(ext_byte_en),
        .external_address_bus(external_address_bus), .ext_data_out(ext_data_out),
        .ext_data_in(ext_data_in), .ext_rdata_valid(ext_rdata_valid));

    // refuses what it cannot serve in two cycles, otherwise runs in step with DUT
    mem_width_pack #(.GENERATION(1)) DUT1 (.clock(clock), .srst(srst),
        .little_endian_select(little_endian_select), .mem_kind(mem_kind),
        .mem_wlog(mem_wlog), .chip_enable_space_one(chip_enable_space_one),
        .req_valid(req_valid), .req_write(req_write), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(g_ready),
        .rsp_valid(g_valid), .rsp_error(g_error), .rsp_rdata(g_rdata),
        .external_address_bus(g_addr), .ext_cmd(g_cmd), .ext_write(g_write),
        .ext_byte_en(g_be), .ext_data_out(g_dout), .ext_data_oe(g_oe),
        .ext_data_in(g_din), .ext_rdata_valid(g_rvalid));

    mem_partner memory1 (.clock(clock), .wlog(mem_wlog), .lag(lag), .ext_cmd(g_cmd),
        .ext_write(g_write), .ext_byte_en(g_be), .external_address_bus(g_addr),
        .ext_data_out(g_dout), .ext_data_in(g_din), .ext_rdata_valid(g_rvalid));

    always #20 clock = ~clock;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // physical lane index of byte address b: unit times eight plus lane
    function automatic int phys(input logic [31:0] b, input logic [1:0] wl, input logic le);
        int wb;
        int m;
        wb = 1 << wl;
        m = int'(b) & (wb - 1);
        return int'(b >> wl) * 8 + (le ? m : wb - 1 - m);
    endfunction : phys

    always @(posedge clock) begin
        if (!srst) begin
            check(ext_data_oe, ext_cmd & ext_write);
            check(ext_cmd & last_cmd, 1'b0);
            if (g_cmd === 1'b1) check(g_addr[1:0], 2'h0);
        end
        last_cmd = ext_cmd;
        if (ext_cmd === 1'b1) begin
            bq_addr.push_back(20'(external_address_bus >> `PIN_BASE_WIDE));
            bq_be.push_back(ext_byte_en);
            bq_d0.push_back(ext_data_out[7:0]);
        end
    end

    task automatic op(input logic wr, input logic [1:0] sz, input logic [31:0] ad,
        input logic [63:0] wd, input logic le, input logic [1:0] wl,
        input logic [1:0] kd, input logic ee);
        logic [63:0] ex;
        int n;
        int p;
        bq_addr.delete();
        bq_be.delete();
        bq_d0.delete();
        req_valid <= 1'b1;
        req_write <= wr;
        req_size <= sz;
        req_addr <= ad;
        req_wdata <= wd;
        little_endian_select <= le;
        mem_wlog <= wl;
        mem_kind <= mem_pack_pkg::mem_kind_e'(kd);
        lag <= 2'($urandom());
        chip_enable_space_one <= 1'($urandom());
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        check(n < 50, 1'b1);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rsp_valid !== 1'b1 && n < 300);
        check(n < 300, 1'b1);
        check(rsp_error, ee);
        ex = '0;
        if (ee) begin
            check(bq_addr.size(), 0);
        end else begin
            for (int i = 0; i < (1 << sz); i++) begin
                p = phys(ad + (le ? i : (1 << sz) - 1 - i), wl, le);
                if (wr) ref_mem[p] = wd[8*i+:8];
                ex[8*i+:8] = ref_mem[p];
            end
            if (!wr) check(rsp_rdata & ~({64{1'b1}} << (8 << sz)), ex);
            check(bq_addr.size(), (sz > wl) ? (1 << (sz - wl)) : 1);
        end
    endtask : op

    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        {clock, req_valid, req_write, little_endian_select, chip_enable_space_one} = '0;
        {mem_wlog, req_size, lag, req_addr, req_wdata, last_cmd} = '0;
        mem_kind = mem_pack_pkg::KIND_ASYNC;
        srst = 1'b1;
        foreach (ref_mem[i]) ref_mem[i] = 8'h00;
        void'($urandom(32'hBA6B));
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        check({req_ready, rsp_valid, ext_cmd, ext_data_oe}, 4'h8);
        w = {$urandom(), $urandom()};
        op(1, 2'h2, 32'h20, w, 1, `WLOG_X8, 0, 0);
        for (int k = 0; k < 4; k++) begin
            check(bq_addr[k], 20'h20 + k);
            check(bq_be[k], 8'h01);
        end
        op(0, 2'h2, 32'h40, 0, 1, `WLOG_X16, 1, 0);
        check(bq_addr[0], 20'h20);
        check(bq_addr[1], 20'h21);
        // big-endian halfword to bytes: the high value byte goes first
        op(1, 2'h1, 32'h30, w, 0, `WLOG_X8, 2, 0);
        check(bq_d0[0], w[15:8]);
        check(bq_d0[1], w[7:0]);
        op(1, 2'h3, 32'h80, w, 1, `WLOG_X64, 0, 0);
        op(0, 2'h2, 32'h80, 0, 0, `WLOG_X64, 0, 0);
        op(0, 2'h2, 32'h2, 0, 1, `WLOG_X32, 0, 1);
        // spans: first byte past the static and the sdram space
        for (int k = 0; k < 4; k++) begin
            op(1, 2'h0, 32'h1 << (20 + k), w, 1, 2'(k), 1, 1);
            op(0, 2'h0, 32'h1 << (25 + k), 0, 0, 2'(k), 2, 1);
        end
        repeat (80) begin
            rs = 2'($urandom());
            w = {$urandom(), $urandom()};
            op(1'($urandom()), rs, 32'($urandom() % 256) & ~((32'h1 << rs) - 1),
               w, 1'($urandom()), 2'($urandom()), 2'($urandom() % 3), 0);
        end
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
